// *** pkg/serial_io_pkg.sv ***
// package for the terminal serial input/output sequencer
// assumes a single 40 MHz clock; all constants shared by hw/ files
package serial_io_pkg;
  // character codes
  localparam logic [7:0] CODE_NUL  = 8'h00;
  localparam logic [7:0] CODE_EOT  = 8'h04;
  localparam logic [7:0] CODE_BEL  = 8'h07;
  localparam logic [7:0] CODE_LF   = 8'h0A;
  localparam logic [7:0] CODE_CR   = 8'h0D;
  localparam logic [7:0] CODE_DEL  = 8'h7F;
  localparam logic [7:0] CODE_CTRL = 8'h1B;  // control prefix word
  // function command codes, following the control prefix
  localparam logic [7:0] CMD_HOME  = 8'h12;
  localparam logic [7:0] CMD_FG    = 8'h1F;
  localparam logic [7:0] CMD_BG    = 8'h19;
  localparam logic [7:0] CMD_CADDR = 8'h11;
  // display geometry
  localparam logic [4:0] LAST_ROW  = 5'h1A;   // row 26
  localparam logic [6:0] LAST_COL  = 7'h49;   // column 73
  // bit and eot counter marks
  localparam logic [3:0] PRINT_END = 4'hC;    // 12
  localparam logic [3:0] RX_NINE   = 4'h9;
  localparam logic [3:0] RX_TEN    = 4'hA;
  localparam logic [1:0] EOT_DONE  = 2'h2;
  // lower case letter range and case bit
  localparam logic [7:0] LC_FIRST  = 8'h61;
  localparam logic [7:0] LC_LAST   = 8'h7A;
  localparam int         CASE_BIT  = 5;        // bit 6 counted from one
  // twelve-bit print frame: stop bits high, data, start low
  localparam logic [11:0] FRAME_IDLE = 12'h0FFF;

  // local side cursor interface
  typedef struct packed {
    logic stepPulse;     // cursor_step_pulse
    logic colSelect;     // column_increment_select
    logic rowSelect;     // row_increment_select
    logic colClear;      // cursor_column_clear
    logic rowClear;      // cursor_row_clear
    logic colStrobe;     // column_load_strobe
    logic rowStrobe;     // row_load_strobe
  } cursor_cmd_t;
endpackage

// *** hw/serial_bit_counter.sv ***
// serial bit counter used by print and receive shifting
// assumes synchronous active-high reset on the same clock
`timescale 1ns/1ps
module serial_bit_counter (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clear,    // return count to zero
  input  wire logic       enable,   // count one bit time
  output logic      [3:0] count     // bits counted so far
);
  // clear wins over enable
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      count <= 4'h0;
    end else if (enable) begin
      count <= count + 4'h1;
    end
  end
endmodule

// *** hw/terminal_serial_io_sequencer.sv ***
// print and receive sequencer of the terminal serial port
// assumes bitTick is one-cycle bit timing from same clock domain
`timescale 1ns/1ps
module terminal_serial_io_sequencer (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       serialIn,      // async line in
  input  wire logic                       bitTick,       // bit time strobe
  input  wire logic                       printReadoutStart,
  input  wire logic                       receivePushbutton,
  input  wire logic                       tapeContinuous, // record cont.
  input  wire logic                       parityOdd,     // parity sense
  input  wire logic [7:0]                 memChar,       // display memory
  input  wire logic                       entrySlot,     // entry time slot
  input  wire logic                       pctrFirst,     // program ctr st1
  input  wire logic                       pctrBusy,
  input  wire logic                       rollCompleteMatch,
  input  wire logic [6:0]                 cursorColumn,
  input  wire logic [4:0]                 cursorRow,
  output logic                            serialOut,
  output logic                            receiveMode,
  output logic                            printMode,
  output logic                            shiftActive,
  output logic                            keyboardLocked,
  output logic                            keyboardLockRequest,
  output logic                            keyboardUnlockRequest,
  output logic                            nonprintableRelease,
  output logic                            wordReadyAck,
  output logic                            memReadRequest,
  output logic                            rollUpRequest,
  output logic                            lineDeleteRoll,
  output logic                            parityOk,
  output logic                            attributeBit,
  output logic                            entryRequest,
  output logic [7:0]                      entryChar,
  output serial_io_pkg::cursor_cmd_t      cursorCmd
);

  ////////////////////////////////////////////////////////////////////
  // state and declarations
  typedef enum {IDLE, NEXTCHAR, SHIFTING} print_state_t;
  print_state_t printState;               // print sequencer
  logic [1:0]  rxSync;                    // serial input synchroniser
  logic        rxLine;                    // synchronised line level
  logic [3:0]  bitCount;                  // shared bit counter
  logic        countClear;                // zero the counter
  logic        countEnable;               // count on bit time
  logic [11:0] txShift;                   // print output frame
  logic [8:0]  rxShift;                   // data and parity bits
  logic        wordReady;                 // received word waiting
  logic        funcEnable;                // next word is a command
  logic [1:0]  addrSeq;                   // cursor address sequence
  logic [1:0]  eotCount;                  // print eot counter
  logic        returnSent;                // cr sent at column zero
  logic        feedSent;                  // lf sent at column zero
  logic        loadWord;                  // word chosen this cycle
  logic [7:0]  nextWord;                  // word to be sent
  logic [7:0]  rxChar;                    // received data byte
  logic        printEnd;                  // print mode ends now
  logic        rxStart;                   // start bit seen
  logic        rxDone;                    // tenth bit time
  logic        printable;                 // received graphic code
  logic        dropCode;                  // received code dropped

  ////////////////////////////////////////////////////////////////////
  // input synchroniser, two flops before any reader
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSync <= 2'h3;
    end else begin
      rxSync <= {rxSync[0], serialIn};
    end
  end
  assign rxLine = rxSync[1];

  serial_bit_counter bitCounter (
    .clk    (clk),
    .reset  (reset),
    .clear  (countClear),
    .enable (countEnable),
    .count  (bitCount)
  );

  ////////////////////////////////////////////////////////////////////
  // combinational decisions
  assign rxChar    = rxShift[7:0];
  assign printEnd  = printMode && eotCount == serial_io_pkg::EOT_DONE
                     && printState == NEXTCHAR;
  assign rxStart   = receiveMode && !shiftActive && !wordReady
                     && !rxLine && bitTick;
  assign rxDone    = receiveMode && shiftActive && bitTick
                     && bitCount == serial_io_pkg::RX_TEN;
  assign printable = rxChar >= 8'h20 && rxChar != serial_io_pkg::CODE_DEL;
  assign dropCode  = rxChar == serial_io_pkg::CODE_DEL
                     || rxChar == serial_io_pkg::CODE_BEL
                     || rxChar == serial_io_pkg::CODE_EOT
                     || rxChar == serial_io_pkg::CODE_LF
                     || rxChar == serial_io_pkg::CODE_NUL || pctrBusy;
  // a pushbutton cut in mid print word must not leave the counter running
  assign countClear  = rxDone || (printMode && shiftActive && bitTick
                       && bitCount == serial_io_pkg::PRINT_END)
                       || (printMode && receivePushbutton);
  assign countEnable = shiftActive && bitTick;

  // word choice for print mode
  always_comb begin
    loadWord       = 1'b0;
    nextWord       = memChar;
    memReadRequest = 1'b0;
    if (printMode && printState == NEXTCHAR && !printEnd) begin
      if (cursorColumn == 7'h00 && !feedSent && !tapeContinuous) begin
        loadWord = 1'b1;
        nextWord = returnSent ? serial_io_pkg::CODE_LF
                              : serial_io_pkg::CODE_CR;
      end else begin
        memReadRequest = 1'b1;
        loadWord       = 1'b1;
        if (memChar == serial_io_pkg::CODE_EOT) begin
          nextWord = eotCount == 2'h0 ? serial_io_pkg::CODE_CR
                                      : serial_io_pkg::CODE_LF;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode flags
  always_ff @(posedge clk) begin
    if (reset) begin
      receiveMode <= 1'b1;
      printMode   <= 1'b0;
    end else if (printEnd || receivePushbutton) begin
      receiveMode <= 1'b1;
      printMode   <= 1'b0;
    end else if (printReadoutStart) begin
      receiveMode <= 1'b0;
      printMode   <= 1'b1;
    end
  end

  // print sequencer and shift register
  always_ff @(posedge clk) begin
    if (reset || !printMode) begin
      printState <= IDLE;
      txShift    <= serial_io_pkg::FRAME_IDLE;
    end else begin
      unique case (printState)
        IDLE:     printState <= NEXTCHAR;
        NEXTCHAR: if (loadWord) begin
          txShift    <= {3'h7, nextWord, 1'b0};
          printState <= SHIFTING;
        end
        SHIFTING: if (countClear) begin
          printState <= NEXTCHAR;
        end else if (bitTick) begin
          txShift <= {1'b1, txShift[11:1]};
        end
      endcase
    end
  end
  assign serialOut = txShift[0];

  // eot counter and column zero memory
  always_ff @(posedge clk) begin
    if (reset || printEnd || !printMode) begin
      eotCount   <= 2'h0;
      returnSent <= 1'b0;
      feedSent   <= 1'b0;
    end else if (loadWord) begin
      if (!memReadRequest) begin
        returnSent <= 1'b1;
        feedSent   <= returnSent;
      end else begin
        returnSent <= 1'b0;
        feedSent   <= 1'b0;
        if (memChar == serial_io_pkg::CODE_EOT && eotCount != 2'h2) begin
          eotCount <= eotCount + 2'h1;
        end else if (memChar == serial_io_pkg::CODE_CR
                     && tapeContinuous) begin
          eotCount <= serial_io_pkg::EOT_DONE;
        end else if (memChar != serial_io_pkg::CODE_EOT) begin
          eotCount <= 2'h0;
        end
      end
    end
  end

  // shift active flag for both directions
  always_ff @(posedge clk) begin
    if (reset) begin
      shiftActive <= 1'b0;
    end else if (countClear || !(printMode || receiveMode)) begin
      shiftActive <= 1'b0;
    end else if (rxStart || (printState == NEXTCHAR && loadWord)) begin
      shiftActive <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive shift register, stops at count nine
  always_ff @(posedge clk) begin
    if (reset) begin
      rxShift <= 9'h000;
    end else if (receiveMode && shiftActive && bitTick
                 && bitCount < serial_io_pkg::RX_NINE) begin
      rxShift <= {rxLine, rxShift[8:1]};
    end
  end

  // word ready, parity, function decode; ready set wins over ack
  always_ff @(posedge clk) begin
    if (reset) begin
      wordReady    <= 1'b0;
      parityOk     <= 1'b1;
      funcEnable   <= 1'b0;
      addrSeq      <= 2'h0;
      attributeBit <= 1'b0;
    end else begin
      if (rxDone) begin
        wordReady <= 1'b1;
        parityOk  <= (^rxShift) == parityOdd;
      end else if (wordReadyAck) begin
        wordReady <= 1'b0;
      end
      if (wordReady && !funcEnable && addrSeq == 2'h0
          && rxChar == serial_io_pkg::CODE_CTRL) begin
        funcEnable <= 1'b1;
      end else if (wordReady && funcEnable) begin
        funcEnable <= 1'b0;
        if (rxChar == serial_io_pkg::CMD_FG) attributeBit <= 1'b1;
        if (rxChar == serial_io_pkg::CMD_BG) attributeBit <= 1'b0;
        if (rxChar == serial_io_pkg::CMD_CADDR) addrSeq <= 2'h1;
      end else if (wordReady && addrSeq != 2'h0) begin
        addrSeq <= addrSeq == 2'h1 ? 2'h2 : 2'h0;
      end
    end
  end

  // received word handling and strobes, one cycle each
  always_comb begin
    cursorCmd           = '0;
    wordReadyAck        = 1'b0;
    nonprintableRelease = 1'b0;
    if (loadWord && memReadRequest) begin
      cursorCmd.stepPulse = !(memChar == serial_io_pkg::CODE_EOT
                              && eotCount == 2'h2);
      cursorCmd.rowSelect = memChar == serial_io_pkg::CODE_CR
        || (memChar == serial_io_pkg::CODE_EOT && eotCount == 2'h1);
      cursorCmd.colSelect = !cursorCmd.rowSelect;
      cursorCmd.colClear  = cursorCmd.rowSelect;
    end else if (wordReady && addrSeq != 2'h0 && !funcEnable) begin
      wordReadyAck        = 1'b1;
      cursorCmd.colStrobe = addrSeq == 2'h1;
      cursorCmd.rowStrobe = addrSeq == 2'h2;
    end else if (wordReady && (funcEnable
                 || rxChar == serial_io_pkg::CODE_CTRL)) begin
      wordReadyAck        = 1'b1;
      nonprintableRelease = 1'b1;
      if (funcEnable && (rxChar == serial_io_pkg::CMD_HOME
                         || rxChar == serial_io_pkg::CMD_CADDR)) begin
        cursorCmd.colClear = 1'b1;
        cursorCmd.rowClear = 1'b1;
      end
    end else if (wordReady && dropCode) begin
      wordReadyAck        = 1'b1;
      nonprintableRelease = 1'b1;
    end else if (wordReady && printable && entrySlot) begin
      wordReadyAck        = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // program counter entry and keyboard lock
  always_ff @(posedge clk) begin
    if (reset) begin
      entryRequest <= 1'b0;
      entryChar    <= 8'h00;
    end else if (wordReady && printable && entrySlot && !funcEnable
                 && addrSeq == 2'h0 && !dropCode) begin
      entryRequest <= 1'b1;
      entryChar    <= (rxChar >= serial_io_pkg::LC_FIRST
                       && rxChar <= serial_io_pkg::LC_LAST)
                      ? (rxChar & ~(8'h01 << serial_io_pkg::CASE_BIT))
                      : rxChar;
    end else if (pctrFirst) begin
      entryRequest <= 1'b0;
    end
  end

  assign keyboardLockRequest   = printReadoutStart || rxStart;
  assign keyboardUnlockRequest = printEnd
                                 || (entryRequest && pctrFirst);
  always_ff @(posedge clk) begin
    if (reset) begin
      keyboardLocked <= 1'b0;
    end else if (keyboardLockRequest) begin
      keyboardLocked <= 1'b1;
    end else if (keyboardUnlockRequest || nonprintableRelease) begin
      keyboardLocked <= 1'b0;
    end
  end

  // roll-up: print end on last row, or a last-column graphic code or a cr taken as cursor address word on last row
  assign rollUpRequest = printEnd
                         && cursorRow == serial_io_pkg::LAST_ROW;
  always_ff @(posedge clk) begin
    if (reset) begin
      lineDeleteRoll <= 1'b0;
    end else if (rollUpRequest || (wordReady && wordReadyAck && !funcEnable
        && cursorRow == serial_io_pkg::LAST_ROW
        && (rxChar == serial_io_pkg::CODE_CR || (printable && !dropCode
        && cursorColumn == serial_io_pkg::LAST_COL)))) begin
      lineDeleteRoll <= 1'b1;
    end else if (rollCompleteMatch) begin
      lineDeleteRoll <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_print_lock: assert property (@(posedge clk) disable iff (reset)
    printReadoutStart && !receivePushbutton |=> printMode && keyboardLocked)
    else $error("print start did not lock");
  chk_eot_end: assert property (@(posedge clk) disable iff (reset)
    printEnd |=> receiveMode && !printMode && eotCount == 2'h0)
    else $error("eot end failed");
  chk_roll_req: assert property (@(posedge clk) disable iff (reset)
    rollUpRequest |-> printEnd && cursorRow == 5'h1A)
    else $error("roll request wrong");
  chk_word_ready: assert property (@(posedge clk) disable iff (reset)
    rxDone |=> wordReady && !shiftActive && bitCount == 4'h0)
    else $error("word ready missing");
  chk_start_lock: assert property (@(posedge clk) disable iff (reset)
    rxStart |=> shiftActive && keyboardLocked)
    else $error("start bit not taken");
  chk_entry_drop: assert property (@(posedge clk) disable iff (reset)
    entryRequest && pctrFirst |=> !entryRequest)
    else $error("entry request held");
  chk_upper_case: assert property (@(posedge clk) disable iff (reset)
    entryRequest |-> !(entryChar >= 8'h61 && entryChar <= 8'h7A))
    else $error("lower case passed");
  chk_print_stop: assert property (@(posedge clk) disable iff (reset)
    printMode && shiftActive && bitTick && bitCount == 4'hC
    |=> !shiftActive && bitCount == 4'h0)
    else $error("print word not ended");
  cov_print_end: cover property (@(posedge clk) printEnd);
  cov_rx_word: cover property (@(posedge clk) rxDone);
  cov_addr_seq: cover property (@(posedge clk) cursorCmd.rowStrobe);
  cov_roll: cover property (@(posedge clk) lineDeleteRoll);
endmodule

// *** tb/serial_host_model.sv ***
// far-side serial host: sends start, 8 data and parity bits per word
// assumes bitTick is the design's bit strobe on the same clock
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       bitTick,   // bit time strobe
  input  wire logic       sendReq,   // one-cycle request to send
  input  wire logic [8:0] sendWord,  // parity then data, lsb first
  output logic            busy,      // frame in flight
  output logic            serialIn   // line toward the design
);
  logic [9:0] frame;  // bits still to go
  int         left;   // count of bits still to go
  assign busy = (left != 0);
  ////////////////////////////////////////////////////////////
  // line changes just after a tick so it is settled by the next
  always @(posedge clk) begin
    if (reset) begin
      left     <= 0;
      serialIn <= 1'b1;  // idle high
    end else if (sendReq && left == 0) begin
      frame <= {sendWord, 1'b0};  // start bit low first
      left  <= 10;
    end else if (bitTick) begin
      if (left > 0) begin
        serialIn <= frame[0];
        frame    <= frame >> 1;
        left     <= left - 1;
      end else begin
        serialIn <= 1'b1;  // released: back to idle level
      end
    end
  end
endmodule

// *** tb/terminal_serial_io_sequencer_tb_top.sv ***
// bench for the serial sequencer: receive, decode and print paths
// assumes the host model in tb/ and the package in pkg/
`timescale 1ns/1ps
module terminal_serial_io_sequencer_tb_top;
  logic clk, reset, serialIn, bitTick, printReadoutStart;
  logic receivePushbutton, pctrFirst, rollCompleteMatch, hostReq, hostBusy;
  logic [7:0] memChar;
  logic [6:0] cursorColumn;
  logic [4:0] cursorRow;
  logic [8:0] hostWord;
  logic       receiveMode, printMode, keyboardLocked, wordReadyAck;
  logic       rollUpRequest, parityOk, attributeBit, entryRequest;
  logic [7:0] entryChar;
  serial_io_pkg::cursor_cmd_t cursorCmd;
  int num_errors, n_compared, tickDiv, nEntry, nHome, nRoll, nAck, nPrint;
  int nRecv, b, c;
  ////////////////////////////////////////////////////////////
  terminal_serial_io_sequencer i_terminal_serial_io_sequencer (
    .clk(clk), .reset(reset), .serialIn(serialIn), .bitTick(bitTick),
    .printReadoutStart(printReadoutStart),
    .receivePushbutton(receivePushbutton), .tapeContinuous(1'b0),
    .parityOdd(1'b0), .memChar(memChar), .entrySlot(1'b1),
    .pctrFirst(pctrFirst), .pctrBusy(1'b0),
    .rollCompleteMatch(rollCompleteMatch), .cursorColumn(cursorColumn),
    .cursorRow(cursorRow), .serialOut(), .receiveMode(receiveMode),
    .printMode(printMode), .shiftActive(), .keyboardLocked(keyboardLocked),
    .keyboardLockRequest(), .keyboardUnlockRequest(),
    .nonprintableRelease(), .wordReadyAck(wordReadyAck),
    .memReadRequest(), .rollUpRequest(rollUpRequest),
    .lineDeleteRoll(), .parityOk(parityOk), .attributeBit(attributeBit),
    .entryRequest(entryRequest), .entryChar(entryChar),
    .cursorCmd(cursorCmd));
  serial_host_model i_serial_host_model (.clk(clk), .reset(reset),
    .bitTick(bitTick), .sendReq(hostReq), .sendWord(hostWord),
    .busy(hostBusy), .serialIn(serialIn));
  ////////////////////////////////////////////////////////////
  // clock, bit strobe every fourth cycle, event counters
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    tickDiv++;
    bitTick = (tickDiv % 4 == 0);
  end
  always @(posedge clk) begin
    if (entryRequest && !$past(entryRequest)) nEntry++;
    if (cursorCmd.colClear && cursorCmd.rowClear) nHome++;
    if (rollUpRequest) nRoll++;
    if (wordReadyAck) nAck++;
    if (printMode && !$past(printMode)) nPrint++;
    if (receiveMode && !$past(receiveMode)) nRecv++;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait until an event counter moves past its base
  task automatic await(ref int cnt, input int base, input string what);
    for (int i = 0; i < 3000 && cnt == base; i++) @(negedge clk);
    if (cnt == base) begin
      num_errors++;
      $display("[ERR] %s expected event seen none", what);
      close_out();
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  // one word through the host model, bad flips the parity bit
  task automatic send(input logic [7:0] d, input logic bad);
    int ackBase;  // own base so the caller's b is left alone
    ackBase = nAck;
    hostWord = {(^d) ^ bad, d};
    pulse(hostReq);
    await(nAck, ackBase, "word ack");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {printReadoutStart, receivePushbutton, pctrFirst} = '0;
    {rollCompleteMatch, hostReq, hostWord, memChar} = '0;
    cursorColumn = 7'h05;
    cursorRow = 5'h03;
    reset = 1'b1;
    void'($urandom(56969));
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk("receive at reset", 8'h01, receiveMode);
    chk("parity at reset", 8'h01, parityOk);
    for (int k = 0; k < 6; k++) begin
      c = (k % 2) ? 32'h61 + $urandom_range(0, 25)
                  : 32'h20 + $urandom_range(0, 94);
      if (c == 32'h7F || c == 32'h1B) c = 32'h41;
      b = nEntry;
      send(c[7:0], 1'b0);
      await(nEntry, b, "entry");
      chk("entry char", (c >= 97 && c <= 122) ? c - 32 : c, entryChar);
      pulse(pctrFirst);
      chk("entry dropped", 8'h00, entryRequest);
    end
    send(8'h42, 1'b1);
    chk("parity flag", 8'h00, parityOk);
    pulse(pctrFirst);
    b = nHome;
    send(serial_io_pkg::CODE_CTRL, 1'b0);
    send(serial_io_pkg::CMD_HOME, 1'b0);
    await(nHome, b, "home clear");
    send(serial_io_pkg::CODE_CTRL, 1'b0);
    send(serial_io_pkg::CMD_FG, 1'b0);
    chk("attribute set", 8'h01, attributeBit);
    send(serial_io_pkg::CODE_CTRL, 1'b0);
    send(serial_io_pkg::CMD_BG, 1'b0);
    chk("attribute clear", 8'h00, attributeBit);
    // print two eot words on the last row: print ends with roll-up
    memChar = serial_io_pkg::CODE_EOT;
    cursorRow = serial_io_pkg::LAST_ROW;
    b = nPrint;
    c = nRecv;
    pulse(printReadoutStart);
    await(nPrint, b, "print on");
    chk("keyboard locked", 8'h01, keyboardLocked);
    b = nRoll;
    await(nRecv, c, "print end");
    chk("print off", 8'h00, printMode);
    await(nRoll, b, "roll request");
    pulse(rollCompleteMatch);
    memChar = 8'h41;
    b = nPrint;
    c = nRecv;
    pulse(printReadoutStart);
    await(nPrint, b, "print again");
    pulse(receivePushbutton);
    await(nRecv, c, "pushbutton receive");
    close_out();
  end
endmodule
